// *** design/rxba_cfg.svh ***
// Register map, field layout and reset constants of the receive buffer accounting bank
`ifndef RXBA_CFG_SVH
`define RXBA_CFG_SVH

`define RXBA_NUM_CH          8
`define RXBA_OFS_W           16
`define RXBA_LVL_W           8
`define RXBA_CNT_W           16
`define RXBA_CH_W            3

// Byte addresses
`define RXBA_ADDR_W          8
`define RXBA_A_OFFSET        8'h00
`define RXBA_A_FILTER        8'h04
`define RXBA_A_CTRL          8'h08
`define RXBA_A_PAUSE_BASE    8'h20
`define RXBA_A_SPARE_BASE    8'h40
`define RXBA_A_BANK_MASK     8'hE0
`define RXBA_A_IDX_LSB       2
`define RXBA_A_IDX_MSB       4

`define RXBA_CTRL_FLOW_EN    0

`define RXBA_RST_OFS         16'h0000
`define RXBA_RST_LVL         8'h00
`define RXBA_RST_CNT         16'h0000
`define RXBA_RST_WORD        32'h0000_0000

`endif

// *** design/rxba_pkg.sv ***
// Types shared by the receive buffer accounting bank
package rxba_pkg;
  typedef enum logic [1:0] {
    RXBA_SEL_NONE,
    RXBA_SEL_PAUSE,
    RXBA_SEL_SPARE
  } rxba_bank_t;
endpackage : rxba_pkg

// *** design/rxba_regs.sv ***
// Receive buffer accounting registers with APB slave, per-channel counters and threshold compares
`timescale 1ns/1ps
`include "rxba_cfg.svh"

module rxba_regs
  import rxba_pkg::*;
#(
  parameter int NUM_CH = `RXBA_NUM_CH
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [31:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  frame_done,
  input  wire logic [`RXBA_CH_W-1:0]                 frame_ch,
  input  wire logic [`RXBA_CNT_W-1:0]                frame_bufs,
  output logic      [`RXBA_OFS_W-1:0]                rx_data_start_offset,
  output logic      [NUM_CH-1:0]                     low_prio_drop,
  output logic      [NUM_CH-1:0]                     flow_ctrl_assert
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Shared data start offset
  logic [`RXBA_OFS_W-1:0]  offset_r;
  // Shared low priority filter level
  logic [`RXBA_LVL_W-1:0]  low_prio_filter_level_r;
  // Flow control master enable
  logic                    flow_en_r;

  // Per-channel pause levels
  logic [`RXBA_LVL_W-1:0]  channel_pause_level_r [NUM_CH];
  // Per-channel spare buffer counters
  logic [`RXBA_CNT_W-1:0]  channel_spare_buffers_r [NUM_CH];

  // ---------------------------------------------------------------
  // Next values of the bus answer and the outputs
  // ---------------------------------------------------------------
  // Selected read word before gating
  logic [31:0]             rd_mux;
  // Bus answer
  logic [31:0]             prdata_nxt;
  logic                    pready_nxt;
  logic                    pslverr_nxt;
  // Channel outputs
  logic [NUM_CH-1:0]       drop_nxt;
  logic [NUM_CH-1:0]       flow_nxt;

  // ---------------------------------------------------------------
  // Bus phase decode
  // ---------------------------------------------------------------
  // Low address byte selects the register, upper bits must be zero
  wire [`RXBA_ADDR_W-1:0]  addr       = paddr[`RXBA_ADDR_W-1:0];
  wire                     upper_zero = (paddr[31:`RXBA_ADDR_W] == '0);
  wire                     word_align = (addr[1:0] == 2'h0);
  wire                     aligned    = word_align && upper_zero;

  // First access cycle raises the answer, the second completes it
  wire                     acc_first  = psel & penable & ~pready;
  wire                     access     = psel & penable & pready;
  wire                     wr_en      = access & pwrite;
  wire                     rd_first   = acc_first & ~pwrite;

  // ---------------------------------------------------------------
  // Register select
  // ---------------------------------------------------------------
  // Global registers sit at fixed words
  wire                     hit_ofs    = aligned && (addr == `RXBA_A_OFFSET);
  wire                     hit_filt   = aligned && (addr == `RXBA_A_FILTER);
  wire                     hit_ctrl   = aligned && (addr == `RXBA_A_CTRL);

  // Channel banks are picked by the upper address bits
  wire [`RXBA_ADDR_W-1:0]  bank_bits  = addr & `RXBA_A_BANK_MASK;
  wire                     in_pause   = (bank_bits == `RXBA_A_PAUSE_BASE);
  wire                     in_spare   = (bank_bits == `RXBA_A_SPARE_BASE);
  wire rxba_bank_t         bank       = !aligned ? RXBA_SEL_NONE :
                                        in_pause ? RXBA_SEL_PAUSE :
                                        in_spare ? RXBA_SEL_SPARE :
                                        RXBA_SEL_NONE;

  // Word index inside a bank names the channel
  wire [`RXBA_CH_W-1:0]    idx        = addr[`RXBA_A_IDX_MSB:`RXBA_A_IDX_LSB];
  wire                     idx_ok     = 32'(idx) < NUM_CH;
  wire                     hit_pause  = (bank == RXBA_SEL_PAUSE) && idx_ok;
  wire                     hit_spare  = (bank == RXBA_SEL_SPARE) && idx_ok;

  // Anything else is answered with an error
  wire                     mapped     = hit_ofs | hit_filt | hit_ctrl | hit_pause | hit_spare;
  wire                     err_first  = acc_first & ~mapped;

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  // One strobe per global register, taken while pready is high
  wire                     wr_ofs     = wr_en && hit_ofs;
  wire                     wr_filt    = wr_en && hit_filt;
  wire                     wr_ctrl    = wr_en && hit_ctrl;
  // Channel strobes, split per channel below
  wire                     wr_pause   = wr_en && hit_pause;
  wire                     wr_spare   = wr_en && hit_spare;
  // Enable bit carried by a control write
  wire                     flow_en_wr = pwdata[`RXBA_CTRL_FLOW_EN];

  // ---------------------------------------------------------------
  // Frame completion event
  // ---------------------------------------------------------------
  // A finished frame on a channel that exists
  wire                     frame_ch_ok = 32'(frame_ch) < NUM_CH;
  wire                     frame_evt   = frame_done && frame_ch_ok;

  // ---------------------------------------------------------------
  // Read words, reserved bits zero
  // ---------------------------------------------------------------
  // Global register words
  wire [31:0]              ofs_word   = 32'(offset_r);
  wire [31:0]              filt_word  = 32'(low_prio_filter_level_r);
  wire [31:0]              ctrl_word  = 32'(flow_en_r) << `RXBA_CTRL_FLOW_EN;
  // Words of the addressed channel
  wire [31:0]              pause_word = 32'(channel_pause_level_r[idx]);
  wire [31:0]              spare_word = 32'(channel_spare_buffers_r[idx]);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read data mux
  always_comb begin
    rd_mux = `RXBA_RST_WORD;
    if (hit_ofs) begin
      rd_mux = ofs_word;
    end else if (hit_filt) begin
      rd_mux = filt_word;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_word;
    end else if (hit_pause) begin
      rd_mux = pause_word;
    end else if (hit_spare) begin
      rd_mux = spare_word;
    end
  end

  // Read data stands only with pready, zero otherwise
  assign prdata_nxt  = rd_first ? rd_mux : `RXBA_RST_WORD;
  // One wait state: the answer follows the first access cycle
  assign pready_nxt  = acc_first;
  // Unmapped or unaligned addresses answer with an error
  assign pslverr_nxt = err_first;

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  // Ready is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_nxt;
    end
  end

  // Error pulses together with ready
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_nxt;
    end
  end

  // Read data stands for the ready cycle only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= `RXBA_RST_WORD;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  // single shared offset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_r <= `RXBA_RST_OFS;
    end else if (wr_ofs) begin
      offset_r <= pwdata[`RXBA_OFS_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_prio_filter_level_r <= `RXBA_RST_LVL;
    end else if (wr_filt) begin
      low_prio_filter_level_r <= pwdata[`RXBA_LVL_W-1:0];
    end
  end

  // Flow control enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flow_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      flow_en_r <= flow_en_wr;
    end
  end

  // ---------------------------------------------------------------
  // Shared compare terms
  // ---------------------------------------------------------------
  // Filter level zero switches low priority dropping off
  wire                     filter_on  = (low_prio_filter_level_r != `RXBA_RST_LVL);
  // Filter level widened to the counter width
  wire [`RXBA_CNT_W-1:0]   filter_cnt = `RXBA_CNT_W'(low_prio_filter_level_r);

  // ---------------------------------------------------------------
  // Per-channel registers and compares
  // ---------------------------------------------------------------
  // eight channel instances
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // Channel match of bus index and of finished frame
    wire                    wr_this   = (32'(idx) == c);
    wire                    frm_this  = (32'(frame_ch) == c);
    // Bus writes and frame event for this channel
    wire                    pause_hit = wr_pause && wr_this;
    wire                    add_hit   = wr_spare && wr_this;
    wire                    sub_hit   = frame_evt && frm_this;
    // Amounts to add and subtract, zero when idle
    wire [`RXBA_CNT_W-1:0]  add_val   = add_hit ? pwdata[`RXBA_CNT_W-1:0] : `RXBA_RST_CNT;
    wire [`RXBA_CNT_W-1:0]  sub_val   = sub_hit ? frame_bufs : `RXBA_RST_CNT;
    // Counter and threshold of this channel
    wire [`RXBA_CNT_W-1:0]  spare_now = channel_spare_buffers_r[c];
    wire [`RXBA_CNT_W-1:0]  pause_cnt = `RXBA_CNT_W'(channel_pause_level_r[c]);
    // Next register values
    logic [`RXBA_CNT_W-1:0] spare_add;
    logic [`RXBA_CNT_W-1:0] spare_nxt;
    logic [`RXBA_LVL_W-1:0] pause_nxt;

    // write adds; wraps at the counter width
    assign spare_add = `RXBA_CNT_W'(spare_now + add_val);
    assign spare_nxt = `RXBA_CNT_W'(spare_add - sub_val);
    assign pause_nxt = pause_hit ? pwdata[`RXBA_LVL_W-1:0] : channel_pause_level_r[c];

    // Pause level register
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        channel_pause_level_r[c] <= `RXBA_RST_LVL;
      end else begin
        channel_pause_level_r[c] <= pause_nxt;
      end
    end

    // Spare buffer counter
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        channel_spare_buffers_r[c] <= `RXBA_RST_CNT;
      end else begin
        channel_spare_buffers_r[c] <= spare_nxt;
      end
    end

    assign drop_nxt[c] = filter_on && (spare_now <= filter_cnt);

    assign flow_nxt[c] = flow_en_r && (spare_now <= pause_cnt);
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // offset for first descriptor; data start byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data_start_offset <= `RXBA_RST_OFS;
    end else begin
      rx_data_start_offset <= offset_r;
    end
  end

  // Low priority drop requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_prio_drop <= '0;
    end else begin
      low_prio_drop <= drop_nxt;
    end
  end

  // Flow control requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flow_ctrl_assert <= '0;
    end else begin
      flow_ctrl_assert <= flow_nxt;
    end
  end

endmodule : rxba_regs

// *** sim/rxba_regs_monitor.sv ***
// Port checks of the receive buffer accounting bank
`timescale 1ns/1ps
module rxba_regs_monitor #(parameter int NUM_CH = 8) (
  input wire logic              clk, sys_rst, psel, penable, pwrite, pready, pslverr, frame_done,
  input wire logic [31:0]       paddr, pwdata, prdata,
  input wire logic [2:0]        frame_ch,
  input wire logic [15:0]       frame_bufs, rx_data_start_offset,
  input wire logic [NUM_CH-1:0] low_prio_drop, flow_ctrl_assert
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Completed write on the bus
  wire wr_done = psel && penable && pwrite && pready;
  property p_rdy_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait"); // (writes land here)
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_err_rdy; pslverr |-> pready && psel && penable; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rst_out; $fell(sys_rst) |-> !pready && rx_data_start_offset == 16'h0000 && flow_ctrl_assert == '0; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not zero after reset");
  property p_ofs_wr; wr_done && paddr == 32'h0000_0000 |=> ##1 rx_data_start_offset == $past(pwdata[15:0], 2); endproperty
  a_ofs_wr: assert property (p_ofs_wr) else $error("offset output wrong after write");
  property p_ofs_hold; !$stable(rx_data_start_offset) |-> $past(wr_done && paddr == 32'h0000_0000, 2); endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("offset changed without write");
  property p_drop_cause; !$stable(low_prio_drop) |-> $past(frame_done || wr_done, 2); endproperty
  a_drop_cause: assert property (p_drop_cause) else $error("drop changed without cause");
  property p_flow_cause; !$stable(flow_ctrl_assert) |-> $past(frame_done || wr_done, 2); endproperty
  a_flow_cause: assert property (p_flow_cause) else $error("flow changed without cause");
endmodule : rxba_regs_monitor

bind rxba_regs rxba_regs_monitor #(.NUM_CH(NUM_CH)) mon_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .frame_ch(frame_ch), .frame_bufs(frame_bufs),
  .rx_data_start_offset(rx_data_start_offset), .low_prio_drop(low_prio_drop), .flow_ctrl_assert(flow_ctrl_assert));

// *** sim/rxba_regs_test.sv ***
// Self-checking bench of the receive buffer accounting bank
`timescale 1ns/1ps
module rxba_regs_test;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, frame_done = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [2:0]  frame_ch = 0;
  logic [15:0] frame_bufs = 0, rx_data_start_offset;
  logic [7:0]  low_prio_drop, flow_ctrl_assert;
  int          n_mismatch = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  rxba_regs #(.NUM_CH(8)) dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
    .frame_ch(frame_ch), .frame_bufs(frame_bufs), .rx_data_start_offset(rx_data_start_offset),
    .low_prio_drop(low_prio_drop), .flow_ctrl_assert(flow_ctrl_assert));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Setup, access, wait for pready, then release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc
  // One frame pulse on a channel
  task automatic frm(input logic [2:0] ch, input logic [15:0] n);
    @(posedge clk);
    frame_done <= 1'b1;
    frame_ch   <= ch;
    frame_bufs <= n;
    @(posedge clk);
    frame_done <= 1'b0;
  endtask : frm
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdc("ofs", 32'h0000_0000, 32'h0000_0000);
    rdc("flt", 32'h0000_0004, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      rdc("pause", 32'h0000_0020 + 4 * i, 32'h0000_0000);
      rdc("spare", 32'h0000_0040 + 4 * i, 32'h0000_0000);
    end
    chk("drop_off", 32'h0000_0000, low_prio_drop);
    apb(1'b1, 32'h0000_0000, 32'hABCD_1234);
    rdc("ofs", 32'h0000_0000, 32'h0000_1234);
    chk("ofs_out", 32'h0000_1234, rx_data_start_offset);
    apb(1'b1, 32'h0000_0000, 32'h0000_0000);
    rdc("ofs0", 32'h0000_0000, 32'h0000_0000);
    chk("ofs0_out", 32'h0000_0000, rx_data_start_offset);
    apb(1'b1, 32'h0000_0004, 32'h0000_01FF);
    rdc("flt", 32'h0000_0004, 32'h0000_00FF);
    chk("drop_all", 32'h0000_00FF, low_prio_drop);
    apb(1'b1, 32'h0000_0004, 32'h0000_0005);
    apb(1'b1, 32'h0000_0048, 32'h0000_000A);
    apb(1'b1, 32'h0000_0048, 32'h0000_000A);
    rdc("spare2", 32'h0000_0048, 32'h0000_0014);
    chk("drop_ch2", 32'h0000_00FB, low_prio_drop);
    frm(3'h2, 16'h000F);
    rdc("spare2_frm", 32'h0000_0048, 32'h0000_0005);
    chk("drop_eq", 32'h0000_00FF, low_prio_drop);
    apb(1'b1, 32'h0000_005C, 32'h1234_FFFF);
    apb(1'b1, 32'h0000_005C, 32'h0000_0002);
    rdc("spare7_wrap", 32'h0000_005C, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 32'h0000_0020 + 4 * i, 32'hFF00_0001 + i);
      rdc("pause", 32'h0000_0020 + 4 * i, 32'h0000_0001 + i);
    end
    chk("flow_off", 32'h0000_0000, flow_ctrl_assert);
    apb(1'b1, 32'h0000_0008, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("flow_on", 32'h0000_00FB, flow_ctrl_assert);
    apb(1'b1, 32'h0000_0004, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("drop_none", 32'h0000_0000, low_prio_drop);
    apb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, er);
    chk("unmapped_rd", 32'h0000_0000, rd);
    tally_and_finish();
  end
endmodule : rxba_regs_test
